// *** hdl/sbg_consts.svh ***
/*
 * Timing counts, field widths and reset values of the baudrate generator
 * and receive error detection. Assumes inclusion by bare name.
 */
`ifndef SBG_CONSTS_SVH
`define SBG_CONSTS_SVH

// ----------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------
`define SBG_RELOAD_W 13
`define SBG_FRAC_W 9
`define SBG_DATA_BITS 8

// ----------------------------------------------------------------
// Prescaler and timer values
// ----------------------------------------------------------------
`define SBG_PRE_MAX_BRS0 2'h1
`define SBG_PRE_MAX_BRS1 2'h2
`define SBG_PRE_ZERO 2'h0
`define SBG_PRE_ONE 2'h1
`define SBG_FRAC_ZERO 9'h000
`define SBG_RELOAD_ZERO 13'h0000
`define SBG_RELOAD_ONE 13'h0001

// ----------------------------------------------------------------
// Oversampling positions (16x async, 4x sync)
// ----------------------------------------------------------------
`define SBG_CNT_ZERO 4'h0
`define SBG_CNT_ONE 4'h1
`define SBG_SMP_FIRST 4'h6
`define SBG_SMP_SECOND 4'h7
`define SBG_SMP_VOTE 4'h8
`define SBG_CNT_LAST 4'hF
`define SBG_Q_ZERO 2'h0
`define SBG_Q_ONE 2'h1
`define SBG_SYNC_SAMPLE 2'h1
`define SBG_SYNC_LAST 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBG_FLAG_RESET 1'b0
`define SBG_LINE_IDLE 1'b1

`endif

// *** hdl/sbg_pkg.sv ***
/*
 * Types shared by the baudrate generator and the receiver.
 * Assumes the constants header is on the include path.
 */
`include "sbg_consts.svh"

package sbg_pkg;
	typedef logic [`SBG_RELOAD_W-1:0] sbg_reload_t;
	typedef logic [`SBG_FRAC_W-1:0] sbg_frac_t;
	typedef enum logic [2:0] {
		SBG_IDLE = 3'h0,
		SBG_START = 3'h1,
		SBG_DATA = 3'h2,
		SBG_PARITY = 3'h3,
		SBG_STOP1 = 3'h4,
		SBG_STOP2 = 3'h5,
		SBG_SYNC = 3'h6
	} sbg_rx_state_t;
endpackage

// *** hdl/sbg_brg_if.sv ***
/*
 * Carrier between the receiver top and the baudrate timer.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps

interface sbg_brg_if;
	import sbg_pkg::*;
	logic async_mode;
	logic frac_div_enable;
	logic fixed_prescale_select;
	sbg_frac_t frac_div_value;
	sbg_reload_t baud_reload;
	logic baud_reload_write;
	logic baud_run_bit;
	logic brt_tick;
	sbg_reload_t timer_value;
	modport gen (
		input async_mode, frac_div_enable, fixed_prescale_select, frac_div_value,
		input baud_reload, baud_reload_write, baud_run_bit,
		output brt_tick, timer_value
	);
	modport user (
		output async_mode, frac_div_enable, fixed_prescale_select, frac_div_value,
		output baud_reload, baud_reload_write, baud_run_bit,
		input brt_tick, timer_value
	);
endinterface

// *** hdl/sbg_timer.sv ***
/*
 * Prescaler (fixed /2, /3 or fractional n/512) and 13-bit reload
 * baudrate timer. Assumes configuration is stable while running.
 */
`timescale 1ns/10ps
`include "sbg_consts.svh"

module sbg_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Generator end of the carrier
	sbg_brg_if.gen brg
);
	import sbg_pkg::*;

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	logic [1:0] pre_q;
	sbg_frac_t acc_q;
	sbg_reload_t cnt_q;
	logic pend_q;
	logic brt_q;
	logic frac_mode_w;
	logic frac_zero_w;
	logic fixed_hit_w;
	logic div_tick_w;
	logic load_w;
	logic underflow_w;
	logic [1:0] pre_max_w;
	logic [`SBG_FRAC_W:0] frac_sum_w;

	assign frac_mode_w = brg.frac_div_enable & brg.async_mode;
	assign pre_max_w = brg.fixed_prescale_select ? `SBG_PRE_MAX_BRS1 : `SBG_PRE_MAX_BRS0;
	assign fixed_hit_w = (pre_q == pre_max_w);
	assign frac_sum_w = {1'b0, acc_q} + {1'b0, brg.frac_div_value};
	assign frac_zero_w = (brg.frac_div_value == `SBG_FRAC_ZERO);
	// Carry of the n/512 accumulator; n of zero passes every clock
	assign div_tick_w = brg.baud_run_bit & (frac_mode_w ? (frac_zero_w | frac_sum_w[`SBG_FRAC_W]) : fixed_hit_w);

	// ----------------------------------------------------------------
	// Reload timer
	// ----------------------------------------------------------------
	// A reload written while halted waits for the run bit
	assign load_w = brg.baud_run_bit & (brg.baud_reload_write | pend_q);
	assign underflow_w = div_tick_w & ~load_w & (cnt_q == `SBG_RELOAD_ZERO);

	always_ff @(posedge clk) begin
		if (reset) begin
			pre_q <= `SBG_PRE_ZERO;
			acc_q <= `SBG_FRAC_ZERO;
		end else begin
			pre_q <= (!brg.baud_run_bit || fixed_hit_w || frac_mode_w) ? `SBG_PRE_ZERO : pre_q + `SBG_PRE_ONE;
			acc_q <= (brg.baud_run_bit && frac_mode_w) ? frac_sum_w[`SBG_FRAC_W-1:0] : `SBG_FRAC_ZERO;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= `SBG_RELOAD_ZERO;
			pend_q <= 1'b0;
			brt_q <= 1'b0;
		end else begin
			pend_q <= brg.baud_run_bit ? 1'b0 : (pend_q | brg.baud_reload_write);
			brt_q <= underflow_w;
			if (load_w || underflow_w) begin
				cnt_q <= brg.baud_reload;
			end else if (div_tick_w) begin
				cnt_q <= cnt_q - `SBG_RELOAD_ONE;
			end
		end
	end

	assign brg.brt_tick = brt_q;
	assign brg.timer_value = cnt_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_fixed_tick;
		div_tick_w && !frac_mode_w;
	endsequence

	AST_PRESCALE_BRS0: assert property (s_fixed_tick ##0 !brg.fixed_prescale_select
		##1 brg.baud_run_bit |-> !div_tick_w ##1 (div_tick_w || !brg.baud_run_bit))
		else $error("fixed prescale by two broken");
	AST_PRESCALE_BRS1: assert property (s_fixed_tick ##0 brg.fixed_prescale_select
		##1 brg.baud_run_bit |-> !div_tick_w ##1 !div_tick_w)
		else $error("fixed prescale by three broken");
	AST_FRAC_ZERO: assert property (brg.baud_run_bit && frac_mode_w && frac_zero_w |-> div_tick_w)
		else $error("zero fraction must pass module clock");
	AST_FRAC_IGNORES_BRS: assert property (brg.baud_run_bit && frac_mode_w && frac_zero_w
		&& brg.fixed_prescale_select ##1 brg.baud_run_bit && frac_mode_w && frac_zero_w |-> div_tick_w)
		else $error("prescale select must be ignored in fractional mode");
	AST_SYNC_NO_FRAC: assert property (div_tick_w && !brg.async_mode && brg.frac_div_enable
		&& !brg.fixed_prescale_select |=> !div_tick_w)
		else $error("fraction applied in synchronous mode");
	AST_HALT: assert property (!brg.baud_run_bit ##1 !brg.baud_run_bit |-> $stable(cnt_q) && !brt_q)
		else $error("timer moved while halted");
	AST_COUNT_DOWN: assert property (div_tick_w && !load_w && cnt_q != `SBG_RELOAD_ZERO
		|=> cnt_q == $past(cnt_q) - `SBG_RELOAD_ONE)
		else $error("timer did not count down");
	AST_UNDERFLOW_RELOAD: assert property (underflow_w |=> brt_q && cnt_q == $past(brg.baud_reload))
		else $error("underflow without pulse and reload");
endmodule

// *** hdl/sbg_top.sv ***
/*
 * Baudrate generator and receiver with framing, parity and overrun
 * detection. Assumes config inputs come from logic on clk and only the
 * serial data pin is asynchronous.
 */
// Overview of operation
// - async timer runs at sixteen times bitrate
// - sample bits at seventh, eighth, ninth ticks
// - fixed async divisors thirty-two or forty-eight
// - reload is unsigned thirteen-bit value
// - fractional prescale n/512, zero means undivided
// - fractional mode ignores prescale select bit
// - timer output is async sample clock
// - synchronous clock four times, never fractional
// - synchronous divisors eight or twelve
// - error request alongside receive request
// - low stop bit sets framing flag
// - parity mismatch sets parity flag
// - unread character at frame end sets overrun
// - timer counts down, gated by run bit
// - underflow gives pulse and reloads timer
`timescale 1ns/10ps
`include "sbg_consts.svh"

module sbg_top #(
	parameter int DATA_BITS = `SBG_DATA_BITS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Baudrate configuration
	input wire logic async_mode,
	input wire logic frac_div_enable,
	input wire logic fixed_prescale_select,
	input wire sbg_pkg::sbg_frac_t frac_div_value,
	input wire sbg_pkg::sbg_reload_t baud_reload,
	input wire logic baud_reload_write,
	input wire logic baud_run_bit,
	// Frame format and receive enable
	input wire logic frame_has_parity,
	input wire logic parity_odd,
	input wire logic two_stop_bits,
	input wire logic rx_enable,
	// Error check enables
	input wire logic framing_check_enable,
	input wire logic parity_check_enable,
	input wire logic overrun_check_enable,
	// Software strobes
	input wire logic rx_buffer_read,
	input wire logic framing_error_clear,
	input wire logic parity_error_clear,
	input wire logic overrun_error_clear,
	// Serial pin
	input wire logic rxd_pin,
	// Clocks towards the channel
	output logic sample_tick,
	output logic bit_tick,
	output logic shift_clk,
	output sbg_pkg::sbg_reload_t timer_value,
	// Receive data and requests
	output logic [DATA_BITS-1:0] rx_data,
	output logic rx_buffer_full,
	output logic receive_irq_request,
	output logic error_irq_request,
	// Error status
	output logic framing_error_flag,
	output logic parity_error_flag,
	output logic overrun_error_flag
);
	import sbg_pkg::*;

	localparam int BW = (DATA_BITS > 1) ? $clog2(DATA_BITS) : 1;
	localparam logic [BW-1:0] LAST_BIT = BW'(DATA_BITS - 1);
	localparam logic [BW-1:0] BIT_ZERO = '0;
	localparam logic [BW-1:0] BIT_ONE = BW'(1);

	if (DATA_BITS < 2 || DATA_BITS > 16) begin : g_bad_width
		$error("DATA_BITS must lie in 2..16");
	end

	// ----------------------------------------------------------------
	// Baudrate timer
	// ----------------------------------------------------------------
	sbg_brg_if brg();

	assign brg.async_mode = async_mode;
	assign brg.frac_div_enable = frac_div_enable;
	assign brg.fixed_prescale_select = fixed_prescale_select;
	assign brg.frac_div_value = frac_div_value;
	assign brg.baud_reload = baud_reload;
	assign brg.baud_reload_write = baud_reload_write;
	assign brg.baud_run_bit = baud_run_bit;

	sbg_timer u_timer (
		.clk(clk),
		.reset(reset),
		.brg(brg)
	);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic rx_meta_q;
	logic rx_sync_q;
	logic rx_prev_q;
	sbg_rx_state_t state_q;
	sbg_rx_state_t state_d;
	logic [3:0] cnt_q;
	logic [1:0] q_q;
	logic [1:0] smp_q;
	logic [BW-1:0] bits_q;
	logic [DATA_BITS-1:0] shift_q;
	logic par_q;
	logic par_bad_q;
	logic stop_bad_q;
	logic sample_tick_q;
	logic bit_tick_q;
	logic shift_clk_q;
	logic [DATA_BITS-1:0] rx_data_q;
	logic buf_full_q;
	logic rx_irq_q;
	logic err_irq_q;
	logic fe_q;
	logic pe_q;
	logic oe_q;

	logic brt_w;
	logic vote_w;
	logic maj_w;
	logic start_w;
	logic sync_start_w;
	logic sync_smp_w;
	logic last_bit_w;
	logic done_async_w;
	logic done_sync_w;
	logic done_w;
	logic fe_set_w;
	logic pe_set_w;
	logic oe_set_w;
	logic err_w;
	logic [DATA_BITS-1:0] sync_word_w;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_meta_q <= `SBG_LINE_IDLE;
			rx_sync_q <= `SBG_LINE_IDLE;
			rx_prev_q <= `SBG_LINE_IDLE;
		end else begin
			rx_meta_q <= rxd_pin;
			rx_sync_q <= rx_meta_q;
			rx_prev_q <= rx_sync_q;
		end
	end

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign brt_w = brg.brt_tick;
	// The timer output itself is the 16x sample clock
	assign vote_w = brt_w & async_mode & (cnt_q == `SBG_SMP_VOTE) & (state_q != SBG_IDLE);
	// Majority of the 7th, 8th and 9th samples rejects a single glitch
	assign maj_w = (smp_q[1] & smp_q[0]) | ((smp_q[1] | smp_q[0]) & rx_sync_q);
	assign start_w = (state_q == SBG_IDLE) & async_mode & rx_enable & baud_run_bit & rx_prev_q & ~rx_sync_q;
	assign sync_start_w = (state_q == SBG_IDLE) & ~async_mode & rx_enable & baud_run_bit;
	assign sync_smp_w = (state_q == SBG_SYNC) & brt_w & (q_q == `SBG_SYNC_SAMPLE);
	assign last_bit_w = (bits_q == LAST_BIT);
	assign done_async_w = vote_w & (((state_q == SBG_STOP1) & ~two_stop_bits) | (state_q == SBG_STOP2));
	assign done_sync_w = sync_smp_w & last_bit_w;
	assign done_w = done_async_w | done_sync_w;
	assign sync_word_w = {rx_sync_q, shift_q[DATA_BITS-1:1]};
	// Stop bits are only checked in asynchronous frames
	assign fe_set_w = done_async_w & framing_check_enable & (stop_bad_q | ~maj_w);
	assign pe_set_w = done_async_w & parity_check_enable & frame_has_parity & par_bad_q;
	assign oe_set_w = done_w & overrun_check_enable & buf_full_q;
	assign err_w = fe_set_w | pe_set_w | oe_set_w;

	// ----------------------------------------------------------------
	// Receive sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			SBG_IDLE: begin
				if (start_w) begin
					state_d = SBG_START;
				end else if (sync_start_w) begin
					state_d = SBG_SYNC;
				end
			end
			SBG_START: if (vote_w) state_d = maj_w ? SBG_IDLE : SBG_DATA;
			SBG_DATA: if (vote_w && last_bit_w) state_d = frame_has_parity ? SBG_PARITY : SBG_STOP1;
			SBG_PARITY: if (vote_w) state_d = SBG_STOP1;
			SBG_STOP1: if (vote_w) state_d = two_stop_bits ? SBG_STOP2 : SBG_IDLE;
			SBG_STOP2: if (vote_w) state_d = SBG_IDLE;
			SBG_SYNC: if (done_sync_w) state_d = SBG_IDLE;
			default: state_d = SBG_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= SBG_IDLE;
			cnt_q <= `SBG_CNT_ZERO;
			q_q <= `SBG_Q_ZERO;
		end else begin
			state_q <= state_d;
			// Restart the 16x phase on the start edge
			if (start_w) begin
				cnt_q <= `SBG_CNT_ZERO;
			end else if (brt_w && async_mode) begin
				cnt_q <= cnt_q + `SBG_CNT_ONE;
			end
			if (sync_start_w) begin
				q_q <= `SBG_Q_ZERO;
			end else if (brt_w && !async_mode) begin
				q_q <= q_q + `SBG_Q_ONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			smp_q <= 2'h3;
		end else if (brt_w && cnt_q == `SBG_SMP_FIRST) begin
			smp_q[1] <= rx_sync_q;
		end else if (brt_w && cnt_q == `SBG_SMP_SECOND) begin
			smp_q[0] <= rx_sync_q;
		end
	end

	// ----------------------------------------------------------------
	// Data, parity and stop accumulation
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			bits_q <= BIT_ZERO;
			shift_q <= '0;
			par_q <= 1'b0;
			par_bad_q <= 1'b0;
			stop_bad_q <= 1'b0;
		end else if (start_w || sync_start_w) begin
			bits_q <= BIT_ZERO;
			par_q <= 1'b0;
			par_bad_q <= 1'b0;
			stop_bad_q <= 1'b0;
		end else if (vote_w && state_q == SBG_DATA) begin
			bits_q <= bits_q + BIT_ONE;
			shift_q <= {maj_w, shift_q[DATA_BITS-1:1]};
			par_q <= par_q ^ maj_w;
		end else if (vote_w && state_q == SBG_PARITY) begin
			par_bad_q <= (par_q ^ maj_w) != parity_odd;
		end else if (vote_w && state_q == SBG_STOP1) begin
			stop_bad_q <= ~maj_w;
		end else if (sync_smp_w) begin
			bits_q <= bits_q + BIT_ONE;
			shift_q <= sync_word_w;
		end
	end

	// ----------------------------------------------------------------
	// Buffer, requests and sticky flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_data_q <= '0;
			buf_full_q <= `SBG_FLAG_RESET;
			rx_irq_q <= 1'b0;
			err_irq_q <= 1'b0;
		end else begin
			if (done_w) begin
				rx_data_q <= done_sync_w ? sync_word_w : shift_q;
			end
			// A new character wins over a read in the same cycle
			buf_full_q <= done_w | (buf_full_q & ~rx_buffer_read);
			rx_irq_q <= done_w;
			err_irq_q <= err_w;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fe_q <= `SBG_FLAG_RESET;
			pe_q <= `SBG_FLAG_RESET;
			oe_q <= `SBG_FLAG_RESET;
		end else begin
			fe_q <= fe_set_w | (fe_q & ~framing_error_clear);
			pe_q <= pe_set_w | (pe_q & ~parity_error_clear);
			oe_q <= oe_set_w | (oe_q & ~overrun_error_clear);
		end
	end

	// ----------------------------------------------------------------
	// Channel clocks
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			sample_tick_q <= 1'b0;
			bit_tick_q <= 1'b0;
			shift_clk_q <= `SBG_LINE_IDLE;
		end else begin
			sample_tick_q <= brt_w & async_mode;
			bit_tick_q <= brt_w & (async_mode ? (cnt_q == `SBG_CNT_LAST) : (q_q == `SBG_SYNC_LAST));
			// Idle high; rises one clock after each synchronous bit is latched
			shift_clk_q <= (state_q != SBG_SYNC) | q_q[1];
		end
	end

	assign sample_tick = sample_tick_q;
	assign bit_tick = bit_tick_q;
	assign shift_clk = shift_clk_q;
	assign timer_value = brg.timer_value;
	assign rx_data = rx_data_q;
	assign rx_buffer_full = buf_full_q;
	assign receive_irq_request = rx_irq_q;
	assign error_irq_request = err_irq_q;
	assign framing_error_flag = fe_q;
	assign parity_error_flag = pe_q;
	assign overrun_error_flag = oe_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_start_vote;
		state_q == SBG_START && vote_w;
	endsequence

	AST_BIT_TICK_16: assert property (brt_w && async_mode && cnt_q == `SBG_CNT_LAST |=> bit_tick_q)
		else $error("bit tick missing at 16th sample");
	AST_FALSE_START: assert property (s_start_vote ##0 (smp_q == 2'h3 && rx_sync_q) |=> state_q == SBG_IDLE)
		else $error("high start bit not rejected");
	AST_GOOD_START: assert property (s_start_vote ##0 (smp_q == 2'h0 && !rx_sync_q) |=> state_q == SBG_DATA)
		else $error("low start bit not accepted");
	AST_SAMPLE_CLOCK: assert property (brt_w && async_mode |=> sample_tick_q)
		else $error("timer output not used as sample clock");
	AST_ERR_WITH_RX: assert property (err_irq_q |-> rx_irq_q)
		else $error("error request without receive request");
	AST_FRAMING: assert property (done_async_w && framing_check_enable && !maj_w
		|=> fe_q && err_irq_q)
		else $error("low stop bit not flagged");
	AST_PARITY: assert property (done_async_w && parity_check_enable && frame_has_parity && par_bad_q
		|=> pe_q && err_irq_q)
		else $error("parity mismatch not flagged");
	AST_OVERRUN: assert property (done_w && overrun_check_enable && buf_full_q |=> oe_q && err_irq_q)
		else $error("overrun not flagged");
	AST_STICKY: assert property (fe_q && !framing_error_clear ##0 pe_q && !parity_error_clear
		|=> fe_q && pe_q)
		else $error("error flag dropped without clear");
endmodule

// *** verification/sbg_peer.sv ***
/*
 * Serial peer that drives the receive line with asynchronous or synchronous frames.
 * Assumes send is raised for one clock while busy is low.
 */
`timescale 1ns/10ps

module sbg_peer (
	// Clock and mode
	input wire logic clk,
	input wire logic async_mode,
	input wire logic shift_clk,
	// Frame request
	input wire logic send,
	input wire logic [7:0] data,
	input wire logic [15:0] bit_clks,
	input wire logic with_parity,
	input wire logic parity_odd,
	input wire logic bad_parity,
	input wire logic stop_low,
	input wire logic two_stop,
	// Line and status
	output logic rxd,
	output logic busy
);
	logic [12:0] bits;
	int n;
	// ----------------
	// Frame driver
	// ----------------
	initial begin
		rxd = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge clk iff send);
			busy = 1'b1;
			if (async_mode) begin
				// Start low, data LSB first, parity, stop bits; only the first stop may be spoiled
				if (with_parity)
					bits = {2'h3, ~stop_low, ^data ^ parity_odd ^ bad_parity, data, 1'b0};
				else
					bits = {3'h7, ~stop_low, data, 1'b0};
				n = 10 + with_parity + two_stop;
				for (int i = 0; i < n; i++) begin
					#1;
					rxd = bits[i];
					repeat (bit_clks) @(posedge clk);
				end
			end else begin
				// New bit after each falling shift clock, latched one clock before the rising one
				for (int i = 0; i < 8; i++) begin
					@(negedge shift_clk);
					#1;
					rxd = data[i];
				end
				@(posedge shift_clk);
			end
			// Line pulled high once released
			#1;
			rxd = 1'b1;
			busy = 1'b0;
		end
	end
endmodule

// *** verification/sbg_top_tb.sv ***
/*
 * Self-checking bench for the baudrate generator and receive error detection.
 * Assumes the design top with its default data width and the serial peer model.
 */
`timescale 1ns/10ps

module sbg_top_tb;
	import sbg_pkg::*;
	logic clk, reset, async_mode, frac_div_enable, fixed_prescale_select, baud_reload_write, baud_run_bit;
	sbg_frac_t frac_div_value;
	sbg_reload_t baud_reload, timer_value, r;
	logic frame_has_parity, parity_odd, two_stop_bits, rx_enable, rx_buffer_read, rxd_pin;
	logic framing_check_enable, parity_check_enable, overrun_check_enable;
	logic framing_error_clear, parity_error_clear, overrun_error_clear;
	logic sample_tick, bit_tick, shift_clk, rx_buffer_full, receive_irq_request, error_irq_request;
	logic framing_error_flag, parity_error_flag, overrun_error_flag;
	logic [7:0] rx_data, tx_byte;
	logic send, bad_parity, stop_low, peer_busy, unread, sel, fde;
	logic [2:0] flg_m;
	logic [15:0] bit_clks;
	sbg_frac_t fdv_tab [3] = '{9'h000, 9'h080, 9'h100};
	int fails, checks, seed, n;

	sbg_top dut (.clk, .reset, .async_mode, .frac_div_enable, .fixed_prescale_select, .frac_div_value,
		.baud_reload, .baud_reload_write, .baud_run_bit, .frame_has_parity, .parity_odd, .two_stop_bits,
		.rx_enable, .framing_check_enable, .parity_check_enable, .overrun_check_enable, .rx_buffer_read,
		.framing_error_clear, .parity_error_clear, .overrun_error_clear, .rxd_pin, .sample_tick, .bit_tick,
		.shift_clk, .timer_value, .rx_data, .rx_buffer_full, .receive_irq_request, .error_irq_request,
		.framing_error_flag, .parity_error_flag, .overrun_error_flag);
	sbg_peer peer (.clk, .async_mode, .shift_clk, .send, .data(tx_byte), .bit_clks,
		.with_parity(frame_has_parity), .parity_odd, .bad_parity, .stop_low, .two_stop(two_stop_bits),
		.rxd(rxd_pin), .busy(peer_busy));

	// ----------------
	// Helpers
	// ----------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic int clks_per_sample(input logic s, input logic f, input sbg_frac_t v, input sbg_reload_t rl);
		int pre;
		pre = !f ? (s ? 3 : 2) : (v == 9'h000 ? 1 : 512 / v);
		return pre * (rl + 1);
	endfunction

	// Halted reload write is deferred, so the count must stay put until run rises
	task automatic setup(input logic am, input logic s, input logic f, input sbg_frac_t v, input sbg_reload_t rl);
		sbg_reload_t t;
		baud_run_bit = 1'b0;
		{async_mode, fixed_prescale_select, frac_div_enable} = {am, s, f};
		frac_div_value = v;
		baud_reload = rl;
		baud_reload_write = 1'b1;
		bit_clks = 16'(16 * clks_per_sample(s, f, v, rl));
		@(negedge clk);
		baud_reload_write = 1'b0;
		t = timer_value;
		repeat (4) @(negedge clk);
		check(timer_value, t);
		baud_run_bit = 1'b1;
		@(negedge clk);
		check(timer_value, rl);
	endtask

	task automatic period(input logic [1:0] src, input int exp);
		int c, k, t0, t1;
		logic prev;
		k = 0;
		t0 = 0;
		t1 = 0;
		prev = shift_clk;
		for (c = 0; k < 2 && c < 20000; c++) begin
			@(negedge clk);
			if (src[0] ? (shift_clk === 1'b1 && prev === 1'b0)
				: (src[1] ? bit_tick : sample_tick) === 1'b1) begin
				if (k == 0)
					t0 = c;
				else
					t1 = c;
				k++;
			end
			prev = shift_clk;
		end
		check(t1 - t0, exp);
	endtask

	task automatic frame(input logic [7:0] d, input logic par, input logic badp, input logic stopl, input logic rd);
		logic err;
		for (n = 0; n < 4000 && peer_busy; n++)
			@(negedge clk);
		{tx_byte, frame_has_parity, bad_parity, stop_low} = {d, par, badp, stopl};
		send = 1'b1;
		@(negedge clk);
		send = 1'b0;
		if (!async_mode) begin
			rx_enable = 1'b1;
			for (n = 0; n < 99 && shift_clk !== 1'b0; n++)
				@(negedge clk);
			rx_enable = 1'b0;
			period(2'h1, (fixed_prescale_select ? 12 : 8) * (baud_reload + 1));
		end
		for (n = 0; n < 9000 && receive_irq_request !== 1'b1; n++)
			@(negedge clk);
		err = async_mode & (framing_check_enable & stopl | parity_check_enable & par & badp);
		err = err | overrun_check_enable & unread;
		flg_m = flg_m | {async_mode & framing_check_enable & stopl, async_mode & parity_check_enable & par & badp,
			overrun_check_enable & unread};
		check(receive_irq_request, 1'b1);
		check(error_irq_request, err);
		check(rx_data, d);
		check({framing_error_flag, parity_error_flag, overrun_error_flag}, flg_m);
		@(negedge clk);
		check({receive_irq_request, error_irq_request}, 2'h0);
		unread = !rd;
		rx_buffer_read = rd;
		@(negedge clk);
		rx_buffer_read = 1'b0;
		check(rx_buffer_full, !rd);
	endtask

	task automatic clear_flags;
		{framing_error_clear, parity_error_clear, overrun_error_clear} = 3'h7;
		@(negedge clk);
		{framing_error_clear, parity_error_clear, overrun_error_clear} = 3'h0;
		flg_m = 3'h0;
		check({framing_error_flag, parity_error_flag, overrun_error_flag}, 3'h0);
	endtask

	// ----------------
	// Tests
	// ----------------
	initial begin
		seed = 10862;
		{fails, checks} = {32'd0, 32'd0};
		{flg_m, unread, reset, send, bad_parity, stop_low, tx_byte} = {3'h0, 5'h08, 8'h00};
		{async_mode, frac_div_enable, fixed_prescale_select, baud_reload_write, baud_run_bit} = 5'h10;
		{frac_div_value, baud_reload} = {9'h000, 13'h0000};
		{frame_has_parity, parity_odd, two_stop_bits, rx_enable, rx_buffer_read} = 5'h00;
		{framing_check_enable, parity_check_enable, overrun_check_enable} = 3'h7;
		{framing_error_clear, parity_error_clear, overrun_error_clear} = 3'h0;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		check({framing_error_flag, parity_error_flag, overrun_error_flag, rx_buffer_full}, 4'h0);
		check({shift_clk, timer_value}, 14'h2000);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			r = 13'($unsigned($random(seed)) % 8);
			sel = i == 1 || (i > 1 && $random(seed) % 2 != 0);
			setup(1'b1, sel, i > 1, i > 1 ? fdv_tab[i - 2] : 9'h000, r);
			period(2'h0, clks_per_sample(sel, i > 1, i > 1 ? fdv_tab[i - 2] : 9'h000, r));
			period(2'h2, int'(bit_clks));
		end
		setup(1'b1, 1'b0, 1'b0, 9'h000, 13'h1FFF);
		$display("test rates done");
		// Low stop, bad parity, then unread buffer: flags must pile up
		setup(1'b1, 1'b0, 1'b0, 9'h000, 13'h0000);
		rx_enable = 1'b1;
		frame(8'hA5, 1'b0, 1'b0, 1'b1, 1'b1);
		frame(8'h3C, 1'b1, 1'b1, 1'b0, 1'b0);
		frame(8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
		clear_flags;
		$display("test corners done");
		for (int i = 0; i < 10; i++) begin
			{sel, fde, parity_odd, two_stop_bits} = 4'($random(seed));
			{framing_check_enable, parity_check_enable, overrun_check_enable} = 3'($random(seed));
			setup(1'b1, sel, fde, fdv_tab[$unsigned($random(seed)) % 3], 13'($unsigned($random(seed)) % 3));
			frame(8'($random(seed)), 1'($random(seed)), $random(seed) % 4 == 0, $random(seed) % 4 == 0, 1'($random(seed)));
			if ($random(seed) % 4 == 0)
				clear_flags;
		end
		$display("test random done");
		// Fraction requested in sync mode must be ignored; a stop_low request, unused by sync frames, is no framing fault
		rx_enable = 1'b0;
		overrun_check_enable = 1'b1;
		for (int i = 0; i < 2; i++) begin
			setup(1'b0, i[0], 1'b1, 9'h080, 13'h0003);
			frame(8'($random(seed)), 1'b0, 1'b0, 1'b1, i[0]);
		end
		$display("test sync done");
		summarize;
	end

	initial begin
		#4000000;
		fails++;
		$display("watchdog expired");
		summarize;
	end
endmodule
